//--- design/adc_result_store.sv
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
`include "adc_store_regs.svh"

// Overview of operation
// - Four byte-wide read-only result registers.
// - Results fill registers zero to three.
// - Power-up leaves result registers undefined.
// - Warm reset keeps result register contents.
// - Internal reference off while converter disabled.
// - Alternate-function bit per pin; zero means digital.
// - All ones routes pins as analog inputs.
// - Digital input buffers blocked unless read, idle.
// - Delay code gives 1..64 conversion clocks.
// - Disabling stops conversion, clears flags and start.
// - Interrupt high with end-of-conversion when enabled.
module adc_result_store
    import adc_store_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             irq,
    input  wire logic        idle_mode,
    output logic [2:0]       mux_channel,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [7:0]  conv_data,
    output logic             internal_ref_on,
    output logic [7:0]       analog_input_pins,
    output logic [7:0]       port_buffer_en,
    input  wire logic [7:0]  shared_port_digital_pins
);

    ////////////////////////////////////////////////////////////////////////////

    state_type st;
    state_type next_st;
    logic      tick;
    logic      burst_end;
    logic      port_read;

    // Last count of the conversion clock divider; reserved codes act as 32.
    function automatic logic [4:0] div_last(input logic [2:0] code);
        case (code)
            3'h0:    div_last = 5'h00;
            3'h1:    div_last = 5'h01;
            3'h2:    div_last = 5'h03;
            3'h3:    div_last = 5'h07;
            3'h4:    div_last = 5'h0F;
            default: div_last = 5'h1F;
        endcase
    endfunction

    // Last count of the sampling delay; the reserved code acts as 64.
    function automatic logic [6:0] delay_last(input logic [2:0] code);
        case (code)
            3'h0:    delay_last = 7'h00;
            3'h1:    delay_last = 7'h01;
            3'h2:    delay_last = 7'h03;
            3'h3:    delay_last = 7'h07;
            3'h4:    delay_last = 7'h0F;
            3'h5:    delay_last = 7'h1F;
            default: delay_last = 7'h3F;
        endcase
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr[1:0] == 2'h0) && (addr <= `OFS_PORT_DIN);
    endfunction

    function automatic logic [31:0] read_value(input state_type s, input logic [7:0] addr);
        read_value = 32'h0000_0000;
        case (addr)
            `OFS_CTRL_ONE: begin
                read_value[`BIT_ENABLE] = s.enable;
                read_value[`BIT_INTERNAL_REFERENCE_SELECT] = s.internal_reference_select;
                read_value[`BIT_CONVERSION_IRQ_ENABLE]   = s.conversion_irq_enable;
            end
            `OFS_CTRL_TWO: begin
                read_value[2:0]        = s.channel;
                read_value[`BIT_CONT]  = s.cont;
                read_value[`BIT_SCAN]  = s.scan;
                read_value[`BIT_START] = s.start;
            end
            `OFS_CTRL_THREE: begin
                read_value[2:0] = s.cdiv;
                read_value[5:3] = s.delay;
            end
            `OFS_STATUS: begin
                read_value[`BIT_EOC]           = s.eoc;
                read_value[`BIT_BUSY]          = (s.eng != ENG_IDLE);
                read_value[`BIT_OVF]           = s.ovf;
                read_value[`LSB_PTR+1:`LSB_PTR] = s.last_ptr;
            end
            `OFS_IRQ_ENABLE: begin
                read_value[`BIT_EOC] = s.conversion_irq_enable;
                read_value[`BIT_OVF] = s.ovf_en;
            end
            `OFS_PORT_ALT: read_value[7:0] = s.alt;
            `OFS_PORT_DIN: read_value[7:0] = s.sync2 & ~s.alt;
            default: begin
                if (addr >= `OFS_RESULT_0 && addr <= `OFS_RESULT_3) begin
                    read_value[7:0] = s.result[addr[3:2] - 2'h2];
                end
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    assign awready         = ~st.aw_held & ~st.bvalid;
    assign wready          = ~st.w_held & ~st.bvalid;
    assign arready         = ~st.rd_busy & ~st.rvalid;
    assign bvalid          = st.bvalid;
    assign bresp           = st.bresp;
    assign rvalid          = st.rvalid;
    assign rdata           = st.rdata;
    assign rresp           = st.rresp;
    assign mux_channel     = st.chan;
    assign conv_start      = st.conv_start;
    assign internal_ref_on = st.enable & st.internal_reference_select;
    assign analog_input_pins = st.alt;
    assign irq = (st.eoc & st.conversion_irq_enable) | (st.ovf & st.ovf_en);

    // Input buffers open only while the core reads the data-in register.
    assign port_read      = st.rd_busy && ({st.rd_idx, 2'h0} == `OFS_PORT_DIN);
    assign port_buffer_en = (port_read && !idle_mode) ? ~st.alt : 8'h00;

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_st            = st;
        next_st.conv_start = 1'b0;
        next_st.sync1      = shared_port_digital_pins;
        next_st.sync2      = st.sync1;
        tick               = (st.div_cnt == 5'h00);
        burst_end          = ~st.scan | (st.ptr == 2'h3);

        // Bus write side: address and data are taken in either order.
        if (awvalid && awready) begin
            next_st.aw_held = 1'b1;
            // A misaligned address is parked on an unmapped index so it answers SLVERR.
            next_st.aw_idx  = (awaddr[1:0] == 2'h0) ? awaddr[7:2] : 6'h3F;
        end
        if (wvalid && wready) begin
            next_st.w_held  = 1'b1;
            next_st.w_data  = wdata[7:0];
            next_st.w_lane0 = wstrb[0];
        end
        if (bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_held && st.w_held) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = mapped({st.aw_idx, 2'h0}) ? `RESP_OKAY : `RESP_SLVERR;
            if (st.w_lane0) begin
                case ({st.aw_idx, 2'h0})
                    `OFS_CTRL_ONE: begin
                        next_st.enable = st.w_data[`BIT_ENABLE];
                        next_st.internal_reference_select = st.w_data[`BIT_INTERNAL_REFERENCE_SELECT];
                        next_st.conversion_irq_enable   = st.w_data[`BIT_CONVERSION_IRQ_ENABLE];
                    end
                    `OFS_CTRL_TWO: begin
                        next_st.channel = st.w_data[2:0];
                        next_st.cont    = st.w_data[`BIT_CONT];
                        next_st.scan    = st.w_data[`BIT_SCAN];
                        next_st.start   = st.w_data[`BIT_START];
                    end
                    `OFS_CTRL_THREE: begin
                        next_st.cdiv  = st.w_data[2:0];
                        next_st.delay = st.w_data[5:3];
                    end
                    `OFS_IRQ_CLEAR: begin
                        next_st.eoc = st.eoc & ~st.w_data[`BIT_EOC];
                        next_st.ovf = st.ovf & ~st.w_data[`BIT_OVF];
                    end
                    `OFS_IRQ_ENABLE: begin
                        next_st.conversion_irq_enable   = st.w_data[`BIT_EOC];
                        next_st.ovf_en = st.w_data[`BIT_OVF];
                    end
                    `OFS_PORT_ALT: next_st.alt = st.w_data;
                    default: begin
                    end
                endcase
            end
        end

        // Bus read side; a port read waits for the pin synchroniser.
        if (arvalid && arready) begin
            next_st.rd_busy = 1'b1;
            next_st.rd_idx  = (araddr[1:0] == 2'h0) ? araddr[7:2] : 6'h3F;
            next_st.rd_wait = (araddr == `OFS_PORT_DIN) ? `PORT_READ_WAIT : 2'h0;
        end
        if (rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (st.rd_busy) begin
            if (st.rd_wait != 2'h0) begin
                next_st.rd_wait = st.rd_wait - 2'h1;
            end else begin
                next_st.rd_busy = 1'b0;
                next_st.rvalid  = 1'b1;
                next_st.rdata   = read_value(st, {st.rd_idx, 2'h0});
                next_st.rresp   = mapped({st.rd_idx, 2'h0}) ? `RESP_OKAY : `RESP_SLVERR;
            end
        end

        // Conversion clock divider, free while a run is under way.
        if (st.eng == ENG_IDLE || tick) begin
            next_st.div_cnt = div_last(st.cdiv);
        end else begin
            next_st.div_cnt = st.div_cnt - 5'h01;
        end

        // Conversion engine; flags set here win over a clear written above.
        case (st.eng)
            ENG_IDLE: begin
                if (st.enable && st.start) begin
                    next_st.eng     = ENG_SAMPLE;
                    next_st.ptr     = 2'h0;
                    next_st.chan    = st.channel;
                    next_st.dly_cnt = delay_last(st.delay);
                end
            end
            ENG_SAMPLE: begin
                if (tick) begin
                    if (st.dly_cnt == 7'h00) begin
                        next_st.conv_start = 1'b1;
                        next_st.eng        = ENG_CONVERT;
                    end else begin
                        next_st.dly_cnt = st.dly_cnt - 7'h01;
                    end
                end
            end
            ENG_CONVERT: begin
                if (conv_done) begin
                    next_st.result[st.ptr] = conv_data;
                    next_st.last_ptr       = st.ptr;
                    next_st.ptr            = st.ptr + 2'h1;
                    if (st.eoc) begin
                        next_st.ovf = 1'b1;
                    end
                    if ((~st.cont & ~st.scan) || st.ptr == 2'h3) begin
                        next_st.eoc = 1'b1;
                    end
                    if (st.scan) begin
                        next_st.chan = burst_end ? st.channel : st.chan + 3'h1;
                    end
                    if ((!st.cont && burst_end) || !st.start) begin
                        next_st.eng = ENG_IDLE;
                        if (!st.cont) begin
                            next_st.start = 1'b0;
                        end
                    end else begin
                        next_st.eng     = ENG_SAMPLE;
                        next_st.dly_cnt = delay_last(st.delay);
                    end
                end
            end
            default: next_st.eng = ENG_IDLE;
        endcase

        // Disabling aborts the run and clears the flags and the start bit.
        if (!next_st.enable) begin
            next_st.eng        = ENG_IDLE;
            next_st.eoc        = 1'b0;
            next_st.ovf        = 1'b0;
            next_st.start      = 1'b0;
            next_st.conv_start = 1'b0;
        end

        // Warm reset clears control state but never touches the results.
        if (rst) begin
            next_st        = '0;
            next_st.eng    = ENG_IDLE;
            next_st.alt    = `RESET_ALT;
            next_st.result = st.result;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

endmodule

//--- design/adc_store_pkg.sv
package adc_store_pkg;

    typedef enum logic [1:0] {
        ENG_IDLE    = 2'b00,
        ENG_SAMPLE  = 2'b01,
        ENG_CONVERT = 2'b10
    } engine_state_type;

    typedef struct packed {
        engine_state_type eng;
        logic             enable;
        logic             internal_reference_select;
        logic             conversion_irq_enable;
        logic             ovf_en;
        logic [2:0]       channel;
        logic             cont;
        logic             scan;
        logic             start;
        logic [2:0]       cdiv;
        logic [2:0]       delay;
        logic             eoc;
        logic             ovf;
        logic [1:0]       ptr;
        logic [1:0]       last_ptr;
        logic [2:0]       chan;
        logic [4:0]       div_cnt;
        logic [6:0]       dly_cnt;
        logic             conv_start;
        logic [3:0][7:0]  result;
        logic [7:0]       alt;
        logic [7:0]       sync1;
        logic [7:0]       sync2;
        logic             aw_held;
        logic [5:0]       aw_idx;
        logic             w_held;
        logic [7:0]       w_data;
        logic             w_lane0;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rd_busy;
        logic [5:0]       rd_idx;
        logic [1:0]       rd_wait;
        logic             rvalid;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
    } state_type;

endpackage

//--- design/adc_store_regs.svh
`ifndef ADC_STORE_REGS_SVH
`define ADC_STORE_REGS_SVH

// Byte offsets on the register bus.
`define OFS_CTRL_ONE    8'h00
`define OFS_CTRL_TWO    8'h04
`define OFS_CTRL_THREE  8'h08
`define OFS_STATUS      8'h0C
`define OFS_IRQ_CLEAR   8'h10
`define OFS_IRQ_ENABLE  8'h14
`define OFS_RESULT_0    8'h18
`define OFS_RESULT_3    8'h24
`define OFS_PORT_ALT    8'h28
`define OFS_PORT_DIN    8'h2C

// Field positions.
`define BIT_ENABLE      0
`define BIT_INTERNAL_REFERENCE_SELECT      1
`define BIT_CONVERSION_IRQ_ENABLE        2
`define BIT_CONT        4
`define BIT_SCAN        5
`define BIT_START       7
`define BIT_EOC         0
`define BIT_BUSY        1
`define BIT_OVF         2
`define LSB_PTR         4
`define LSB_DELAY       3

// Reset values of control state.
`define RESET_BYTE      8'h00
`define RESET_ALT       8'h00

// Extra cycles a port data-in read waits for the two-stage pin synchroniser.
`define PORT_READ_WAIT  2'h3

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

//--- verification/adc_analog_model.sv
`timescale 1ns/1ps
module adc_analog_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       conv_start,
    input  wire logic [2:0] mux_channel,
    input  wire logic       slow,
    output logic            conv_done,
    output logic [7:0]      conv_data
);
    logic       busy;
    logic [3:0] cnt;
    logic [2:0] ch;

    // Data is only meaningful with the done pulse; otherwise it toggles so a late capture shows up.
    always_ff @(posedge mclk) begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (rst) begin
            busy      <= 1'b0;
            conv_data <= 8'h00;
        end else if (conv_start) begin
            busy <= 1'b1;
            cnt  <= slow ? 4'hE : 4'h1;
            ch   <= mux_channel;
        end else if (busy && cnt == 4'h0) begin
            busy      <= 1'b0;
            conv_done <= 1'b1;
            conv_data <= {5'h14, ch};
        end else if (busy) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule

//--- verification/adc_result_store_and_input_select_tb.sv
`timescale 1ns/1ps
module adc_result_store_and_input_select_tb;
    logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready, idle_mode, slow;
    logic        awready, wready, bvalid, arready, rvalid, irq, conv_start, conv_done, internal_ref_on;
    logic [7:0]  awaddr, araddr, pins, buf_seen, conv_data, analog_input_pins, port_buffer_en;
    logic [31:0] wdata, rdata, rd_val;
    logic [3:0]  wstrb;
    logic [1:0]  wr_resp, rd_resp, bresp, rresp;
    logic [2:0]  mux_channel;
    int          bad_count, check_count, n, base, i;
    // Row: address, write data, expected read data, expected response.
    logic [25:0] rows [7] = '{{8'h08, 8'h2D, 8'h2D, 2'h0}, {8'h14, 8'h05, 8'h05, 2'h0},
        {8'h28, 8'hA5, 8'hA5, 2'h0}, {8'h28, 8'hFF, 8'hFF, 2'h0}, {8'h10, 8'h05, 8'h00, 2'h0},
        {8'h2E, 8'h01, 8'h00, 2'h2}, {8'h40, 8'h01, 8'h00, 2'h2}};

    adc_result_store DUT (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq), .idle_mode(idle_mode),
        .mux_channel(mux_channel), .conv_start(conv_start), .conv_done(conv_done), .conv_data(conv_data),
        .internal_ref_on(internal_ref_on), .analog_input_pins(analog_input_pins),
        .port_buffer_en(port_buffer_en), .shared_port_digital_pins(pins));
    adc_analog_model model (.mclk(mclk), .rst(rst), .conv_start(conv_start), .mux_channel(mux_channel),
        .slow(slow), .conv_done(conv_done), .conv_data(conv_data));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic time_out();
        bad_count++;
        $display("Error %0t: wait ran out", $time);
        finish_test();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Each bus task starts on a fresh edge so no strobe is driven twice in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int k;
        @(posedge mclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && k < 200);
        wr_resp = bresp;
        bready <= 1'b0;
        if (k >= 200) time_out();
    endtask

    task automatic rd(input logic [7:0] a);
        int k;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        k = 0;
        buf_seen = 8'h00;
        do begin
            @(posedge mclk);
            k++;
            buf_seen |= port_buffer_en;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && k < 200);
        rd_val = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
        if (k >= 200) time_out();
    endtask

    task automatic wait_irq();
        int k;
        for (k = 0; k < 3000 && irq !== 1'b1; k++) @(posedge mclk);
        if (k >= 3000) time_out();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, idle_mode, slow} = 7'h00;
        {awaddr, araddr} = 16'h0000;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        pins = 8'h5A;
        rst = 1'b1;
        bad_count = 0;
        check_count = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 7; i++) begin
            wr(rows[i][25:18], rows[i][17:10]);
            chk(wr_resp, rows[i][1:0]);
            rd(rows[i][25:18]);
            chk(rd_resp, rows[i][1:0]);
            if (rows[i][1:0] == 2'h0) chk(rd_val, rows[i][9:2]);
            if (rows[i][25:18] == 8'h28) chk(analog_input_pins, rows[i][17:10]);
        end
        for (i = 0; i < 4; i++) wr(8'h18 + 8'(4 * i), 8'h00);
        for (i = 0; i < 4; i++) begin
            wr(8'h00, {6'h00, i[1:0]});
            #1 chk(internal_ref_on, i == 3);
        end
        // Every sampling code, hold point measured against code zero.
        wr(8'h00, 8'h05);
        for (i = 0; i < 8; i++) begin
            wr(8'h08, {2'b00, i[2:0], 3'b000});
            wr(8'h04, 8'h80);
            n = 0;
            do begin
                @(negedge mclk);
                n++;
            end while (conv_start !== 1'b1 && n < 300);
            if (n >= 300) time_out();
            if (i == 0) base = n;
            else chk(32'(n - base), 32'((i == 7) ? 63 : (1 << i) - 1));
            wait_irq();
            wr(8'h10, 8'h01);
        end
        wr(8'h08, 8'h00);
        wr(8'h04, 8'hA6);
        wait_irq();
        for (i = 0; i < 4; i++) begin
            rd(8'h18 + 8'(4 * i));
            chk(rd_val, 32'hA0 + 32'((6 + i) % 8));
        end
        rd(8'h0C);
        chk(rd_val & 32'h31, 32'h31);
        wr(8'h18, 8'h55);
        rd(8'h18);
        chk(rd_val, 32'hA6);
        wr(8'h00, 8'h01);
        #1 chk(irq, 1'b0);
        wr(8'h00, 8'h05);
        #1 chk(irq, 1'b1);
        wr(8'h10, 8'h01);
        #1 chk(irq, 1'b0);
        slow <= 1'b1;
        wr(8'h04, 8'h82);
        wait_irq();
        rst <= 1'b1;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 2; i++) begin
            rd(8'h18 + 8'(4 * i));
            chk(rd_val, (i == 1) ? 32'hA7 : 32'hA2);
        end
        rd(8'h00);
        chk({rd_val[7:0], irq, internal_ref_on}, 32'h0);
        // Continuous run until a second pass sets the overflow flag, then disable.
        wr(8'h00, 8'h05);
        wr(8'h04, 8'h90);
        wait_irq();
        repeat (100) @(posedge mclk);
        rd(8'h0C);
        chk(rd_val & 32'h07, 32'h07);
        wr(8'h00, 8'h00);
        rd(8'h0C);
        chk(rd_val & 32'h07, 32'h0);
        rd(8'h04);
        chk(rd_val, 32'h10);
        for (i = 0; i < 3; i++) begin
            idle_mode <= (i == 2);
            wr(8'h28, (i > 0) ? 8'h0F : 8'h00);
            rd(8'h2C);
            chk(buf_seen, (i == 2) ? 8'h00 : ((i == 1) ? 8'hF0 : 8'hFF));
            if (i < 2) chk(rd_val, (i == 1) ? 32'h50 : 32'h5A);
        end
        finish_test();
    end
endmodule

//--- verification/adc_store_chk.sv
`timescale 1ns/1ps
module adc_store_chk (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        awready,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic        irq,
    input wire logic        idle_mode,
    input wire logic        conv_start,
    input wire logic        conv_done,
    input wire logic        internal_ref_on,
    input wire logic [7:0]  analog_input_pins,
    input wire logic [7:0]  port_buffer_en
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_write_stands: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped early");
    a_read_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    a_byte_wide: assert property (rvalid |-> rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_ref_on_write: assert property ($rose(internal_ref_on) |-> $rose(bvalid))
        else $error("reference turned on without a write");
    a_alt_on_write: assert property ($changed(analog_input_pins) && !$past(rst) |-> $rose(bvalid))
        else $error("pin routing changed without a write");
    a_buf_digital: assert property ((port_buffer_en & analog_input_pins) == 8'h00)
        else $error("buffer open on an analog pin");
    a_buf_idle: assert property (idle_mode && $past(idle_mode) |-> port_buffer_en == 8'h00)
        else $error("buffer open in idle");
    a_buf_on_read: assert property (port_buffer_en != 8'h00 |-> !arready)
        else $error("buffer open outside a read");
    a_irq_cause: assert property ($rose(irq) |-> $past(conv_done) || $rose(bvalid))
        else $error("interrupt rose without cause");
    a_irq_drop: assert property ($fell(irq) && !$past(rst) |-> $rose(bvalid))
        else $error("interrupt fell without a write");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("hold pulse longer than one cycle");

    c_done: cover property (conv_done);
    c_irq: cover property ($rose(irq));
    c_port_read: cover property (port_buffer_en == 8'hFF);
endmodule

bind adc_result_store adc_store_chk u_chk (.mclk(mclk), .rst(rst), .awready(awready), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .irq(irq), .idle_mode(idle_mode), .conv_start(conv_start), .conv_done(conv_done),
    .internal_ref_on(internal_ref_on), .analog_input_pins(analog_input_pins), .port_buffer_en(port_buffer_en));
